// >>> rtl/lrx_consts.vh
/*
 * Constants for the receive-side link event counting block: register map,
 * field positions, event codes, message classes, flit kinds, power modes.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef LRX_CONSTS_VH
`define LRX_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define LRX_OFF_CTL0 8'h00
`define LRX_OFF_CNT0 8'h10
`define LRX_OFF_STAT 8'h20
`define LRX_OFF_STEP 8'h04
`define LRX_ADDR_W 8

// ****************************************
// Control register fields
// ****************************************
`define LRX_CTL_CODE_LSB 0
`define LRX_CTL_UMASK_LSB 8
`define LRX_CTL_EDGE_BIT 18
`define LRX_CTL_EXT_BIT 21
`define LRX_CTL_EN_BIT 22
`define LRX_CTL_RST 32'h0000_0000

// ****************************************
// Event codes
// ****************************************
`define LRX_EV_FLIT_G0 8'h01
`define LRX_EV_BYPASS 8'h09
`define LRX_EV_RXQ_NE 8'h0A
`define LRX_EV_FULL_PWR 8'h0F
`define LRX_EV_HALF_PWR 8'h10
`define LRX_EV_CRED_SHR 8'h1D
`define LRX_EV_CRED_DED 8'h1E

// ****************************************
// Flit kinds, group-0 mask bits
// ****************************************
`define LRX_FLIT_IDLE 2'h0
`define LRX_FLIT_DATA 2'h1
`define LRX_FLIT_NONDATA 2'h2
`define LRX_G0_IDLE_BIT 0
`define LRX_G0_DATA_BIT 1
`define LRX_G0_NONDATA_BIT 2

// ****************************************
// Message classes (dedicated network mask bit index)
// ****************************************
`define LRX_CLS_DATA_RSP 3'h0
`define LRX_CLS_NC_BYPASS 3'h1
`define LRX_CLS_NC_STD 3'h2
`define LRX_CLS_HOME 3'h3
`define LRX_CLS_SNOOP 3'h4
`define LRX_CLS_NONDATA_RSP 3'h5
`define LRX_VNET_DEDICATED 1'b0
`define LRX_VNET_SHARED 1'b1

// ****************************************
// Receive power modes, flit framing
// ****************************************
`define LRX_PWR_FULL 2'h0
`define LRX_PWR_HALF 2'h1
`define LRX_PWR_SHUT 2'h2
`define LRX_PWR_TRAIN 2'h3
`define LRX_FLIT_BITS 7'h50
`define LRX_UNIT_FULL 5'h14
`define LRX_UNIT_HALF 5'h0A
`define LRX_UNITS_FULL 4'h4
`define LRX_UNITS_HALF 4'h8

`endif

// >>> rtl/lrx_count.v
/*
 * One general-purpose event counter: adds a per-cycle increment of 0..2.
 * Assumes load and increment come from logic on the same clock.
 */
`timescale 1ns/1ps
module lrx_count #(
	parameter W = 32
) (
	// Clock, reset, enable
	input wire clk_sys_i,
	input wire srst_i,
	input wire ce_i,
	// Control
	input wire en_i,
	input wire load_i,
	input wire [W-1:0] load_val_i,
	input wire [1:0] inc_i,
	// Count
	output wire [W-1:0] cnt_o
);
	reg [W-1:0] cnt_q;
	wire [W-1:0] cnt_d;

	// Software load takes priority over counting in the same cycle
	assign cnt_d = load_i ? load_val_i :
		(en_i ? cnt_q + {{(W-2){1'b0}}, inc_i} : cnt_q);

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			cnt_q <= {W{1'b0}};
		end else if (ce_i) begin
			cnt_q <= cnt_d;
		end
	end

	assign cnt_o = cnt_q;
endmodule // lrx_count

// >>> rtl/lrx_evsel.v
/*
 * Event selection for one counter: decodes code, mask and extra select into
 * an increment of 0..2, with optional edge detection.
 * Assumes all event inputs are on the counter's clock.
 */
`timescale 1ns/1ps
`include "lrx_consts.vh"
module lrx_evsel (
	// Clock, reset, enable
	input wire clk_sys_i,
	input wire srst_i,
	input wire ce_i,
	// Selection
	input wire [7:0] code_i,
	input wire [7:0] umask_i,
	input wire ext_i,
	input wire edge_i,
	// Events
	input wire ev_full_i,
	input wire ev_half_i,
	input wire ev_bypass_i,
	input wire ev_rxq_ne_i,
	input wire ev_cred_ded_i,
	input wire ev_cred_shr_i,
	input wire [1:0] flit_idle_i,
	input wire [1:0] flit_data_i,
	input wire [1:0] flit_nondata_i,
	// Increment
	output reg [1:0] inc_o
);
	reg prev_q;
	reg [1:0] raw;
	reg [1:0] g0;
	integer i;

	always @* begin
		g0 = 2'h0;
		for (i = 0; i < 2; i = i + 1) begin
			if ((flit_idle_i[i] && umask_i[`LRX_G0_IDLE_BIT]) ||
				(flit_data_i[i] && umask_i[`LRX_G0_DATA_BIT]) ||
				(flit_nondata_i[i] && umask_i[`LRX_G0_NONDATA_BIT])) begin
				g0 = g0 + 2'h1;
			end
		end
		raw = 2'h0;
		case ({ext_i, code_i})
		{1'b0, `LRX_EV_HALF_PWR}: raw = {1'b0, ev_half_i};
		{1'b0, `LRX_EV_FULL_PWR}: raw = {1'b0, ev_full_i};
		{1'b0, `LRX_EV_BYPASS}: raw = {1'b0, ev_bypass_i};
		{1'b1, `LRX_EV_CRED_DED}: raw = {1'b0, ev_cred_ded_i};
		{1'b1, `LRX_EV_CRED_SHR}: raw = {1'b0, ev_cred_shr_i};
		{1'b0, `LRX_EV_RXQ_NE}: raw = {1'b0, ev_rxq_ne_i};
		{1'b0, `LRX_EV_FLIT_G0}: raw = g0;
		default: raw = 2'h0;
		endcase
		// Edge mode counts entries into a condition, not cycles in it
		if (edge_i) begin
			inc_o = {1'b0, (raw != 2'h0) && !prev_q};
		end else begin
			inc_o = raw;
		end
	end

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			prev_q <= 1'b0;
		end else if (ce_i) begin
			prev_q <= (raw != 2'h0);
		end
	end
endmodule // lrx_evsel

// >>> rtl/lrx_event_top.v
/*
 * Receive-side link event generation and four event counters, with an
 * AHB-Lite register slave for control, counts and status.
 * Assumes link-side inputs come from logic on clk_sys_i; a single bus slave.
 */
`timescale 1ns/1ps
`include "lrx_consts.vh"

// Summary of operation
// - Code 0x10 counts cycles with receive side in half-lane mode, one per cycle.
// - Half-lane mode switches off half of the receive lanes to save power.
// - Edge detect makes the half-lane event count entries into that mode.
// - Residency events follow only the receive direction's own power state.
// - Code 0x0F counts cycles in full-power mode, the default, one per cycle.
// - Edge detect makes the full-power event count entries into full power.
// - Training periods away from full power are not counted as full power.
// - Code 0x09 counts each flit that bypasses the buffer into the egress.
// - Code 0x1E with extra select counts dedicated network credits consumed.
// - Mask bits 15:8 pick classes: data rsp, nc bypass, nc std, home, snoop, non-data.
// - Code 0x1D with extra select counts shared network credits consumed.
// - Code 0x0A counts cycles where the receive queue holds an entry.
// - Code 0x01 counts received flits by category, up to two per cycle.
// - A flit is 80 bits: four 20-bit units, or eight 10-bit units at half width.
// - Group-0 mask: bit 0 idle/null, bit 1 data, bit 2 non-data protocol.
// - Data selection counts 64-bit payload flits of both channels, not headers.
// - Non-data selection counts non-null non-data flits including data headers.
module lrx_event_top #(
	parameter NCNT = 4,
	parameter CNT_W = 32,
	parameter LANES = 20
) (
	// Clock, reset, enable
	input wire clk_sys_i,
	input wire srst_i,
	input wire ce_i,
	// AHB-Lite slave
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output wire [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	// Receive link layer status
	input wire [1:0] rx_pwr_mode_i,
	input wire [1:0] flit_vld_i,
	input wire [1:0] flit0_kind_i,
	input wire [1:0] flit1_kind_i,
	input wire bypass_i,
	input wire credit_vld_i,
	input wire credit_vnet_i,
	input wire [2:0] credit_class_i,
	input wire rxq_nonempty_i,
	// Receive lane control
	output wire [LANES-1:0] rx_lane_en_o,
	output wire [4:0] rx_unit_width_o,
	output wire [3:0] rx_units_per_flit_o,
	output wire [1:0] rx_pwr_state_o
);
	// ****************************************
	// Local constants
	// ****************************************
	localparam [1:0] ST_FULL = `LRX_PWR_FULL;
	localparam [1:0] ST_HALF = `LRX_PWR_HALF;
	localparam [1:0] ST_SHUT = `LRX_PWR_SHUT;
	localparam [1:0] ST_TRAIN = `LRX_PWR_TRAIN;
	localparam [LANES-1:0] LANES_ALL = {LANES{1'b1}};
	localparam [LANES-1:0] LANES_HALF = {LANES{1'b1}} >> (LANES / 2);
	localparam [1:0] HTRANS_NONSEQ = 2'h2;
	localparam [1:0] HTRANS_SEQ = 2'h3;
	localparam [1:0] BUS_IDLE = 2'h0;
	localparam [1:0] BUS_WRITE = 2'h1;
	localparam [1:0] BUS_READ = 2'h2;

	// ****************************************
	// Declarations
	// ****************************************
	// Power state and lane control
	reg [1:0] pwr_q;
	reg [1:0] pwr_d;
	reg [LANES-1:0] lane_en_q;
	reg [LANES-1:0] lane_en_d;
	reg [4:0] unit_w_q;
	reg [4:0] unit_w_d;
	reg [3:0] units_q;
	reg [3:0] units_d;
	wire ev_full;
	wire ev_half;

	// Bus slave
	reg [1:0] bus_st_q;
	reg [1:0] bus_st_d;
	reg [`LRX_ADDR_W-1:0] addr_q;
	reg [31:0] hrdata_q;
	reg [31:0] hrdata_d;
	reg hready_q;
	reg hresp_q;
	wire bus_take;
	wire wr_pend;
	wire rd_pend;
	wire wr_ctl;
	wire wr_cnt;

	// Control registers and counters
	reg [31:0] ctl_q [0:NCNT-1];
	wire [CNT_W-1:0] cnt [0:NCNT-1];
	wire [1:0] inc [0:NCNT-1];
	integer k;

	// Link events
	wire ev_cred_ded;
	wire ev_cred_shr;
	wire [1:0] flit_idle;
	wire [1:0] flit_data;
	wire [1:0] flit_nondata;
	wire [1:0] kind [0:1];

	// ****************************************
	// Receive power state
	// ****************************************
	// Only the receive direction's own mode is tracked here
	always @* begin
		pwr_d = rx_pwr_mode_i;
		lane_en_d = LANES_ALL;
		unit_w_d = `LRX_UNIT_FULL;
		units_d = `LRX_UNITS_FULL;
		case (rx_pwr_mode_i)
		ST_FULL: begin
			lane_en_d = LANES_ALL;
			unit_w_d = `LRX_UNIT_FULL;
			units_d = `LRX_UNITS_FULL;
		end
		ST_HALF: begin
			// Upper half of the lanes idles to save power
			lane_en_d = LANES_HALF;
			unit_w_d = `LRX_UNIT_HALF;
			units_d = `LRX_UNITS_HALF;
		end
		ST_SHUT: begin
			// Link off: no lanes, no framing
			lane_en_d = {LANES{1'b0}};
			unit_w_d = 5'h00;
			units_d = 4'h0;
		end
		ST_TRAIN: begin
			// Training keeps lanes up but is not full-power operation
			lane_en_d = LANES_ALL;
			unit_w_d = `LRX_UNIT_FULL;
			units_d = `LRX_UNITS_FULL;
		end
		default: begin
			pwr_d = ST_FULL;
		end
		endcase
	end

	// Registered mode decode keeps every lane output on a flip-flop
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			pwr_q <= ST_FULL;
			lane_en_q <= LANES_ALL;
			unit_w_q <= `LRX_UNIT_FULL;
			units_q <= `LRX_UNITS_FULL;
		end else if (ce_i) begin
			pwr_q <= pwr_d;
			lane_en_q <= lane_en_d;
			unit_w_q <= unit_w_d;
			units_q <= units_d;
		end
	end

	// Residency follows the registered state, one cycle after the mode input
	assign ev_full = (pwr_q == ST_FULL);
	assign ev_half = (pwr_q == ST_HALF);

	// ****************************************
	// Flit and credit decode
	// ****************************************
	assign kind[0] = flit0_kind_i;
	assign kind[1] = flit1_kind_i;

	// Up to two flits a cycle; kind 3 is never counted
	genvar s;
	generate
		for (s = 0; s < 2; s = s + 1) begin : g_slot
			// Idle covers null flits too; headers of data packets arrive as non-data
			assign flit_idle[s] = flit_vld_i[s] && (kind[s] == `LRX_FLIT_IDLE);
			assign flit_data[s] = flit_vld_i[s] && (kind[s] == `LRX_FLIT_DATA);
			assign flit_nondata[s] = flit_vld_i[s] && (kind[s] == `LRX_FLIT_NONDATA);
		end
	endgenerate

	assign ev_cred_shr = credit_vld_i && (credit_vnet_i == `LRX_VNET_SHARED);
	assign ev_cred_ded = credit_vld_i && (credit_vnet_i == `LRX_VNET_DEDICATED);

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	// Writes complete with no wait state; reads take one so that a read
	// right after a write sees the written value.
	assign bus_take = hsel_i && hready_i &&
		(htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);

	// A read spends exactly one cycle in BUS_READ; hready is low then,
	// so no new address phase can be taken in that cycle.
	always @* begin
		bus_st_d = BUS_IDLE;
		case (bus_st_q)
		BUS_IDLE, BUS_WRITE: begin
			if (bus_take) begin
				bus_st_d = hwrite_i ? BUS_WRITE : BUS_READ;
			end
		end
		BUS_READ: begin
			bus_st_d = BUS_IDLE;
		end
		default: begin
			bus_st_d = BUS_IDLE;
		end
		endcase
	end

	// Data phase qualifiers follow the previous address phase
	assign wr_pend = (bus_st_q == BUS_WRITE);
	assign rd_pend = (bus_st_q == BUS_READ);
	assign wr_ctl = wr_pend && (addr_q < `LRX_OFF_CNT0);
	assign wr_cnt = wr_pend && (addr_q[`LRX_ADDR_W-1:4] == 4'h1);

	// Read mux works on the address latched in the address phase
	always @* begin
		hrdata_d = 32'h0000_0000;
		if (addr_q < `LRX_OFF_CNT0) begin
			hrdata_d = ctl_q[addr_q[3:2]];
		end else if (addr_q < `LRX_OFF_STAT) begin
			hrdata_d = cnt[addr_q[3:2]];
		end else if (addr_q == `LRX_OFF_STAT) begin
			hrdata_d = {29'h0, rxq_nonempty_i, pwr_q};
		end
	end

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			bus_st_q <= BUS_IDLE;
			addr_q <= {`LRX_ADDR_W{1'b0}};
			hrdata_q <= 32'h0000_0000;
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end else if (ce_i) begin
			bus_st_q <= bus_st_d;
			if (bus_take) begin
				addr_q <= haddr_i[`LRX_ADDR_W-1:0];
			end
			// Wait state only while the read data is fetched
			hready_q <= (bus_st_d != BUS_READ);
			// Slave never signals an error
			hresp_q <= 1'b0;
			if (rd_pend) begin
				hrdata_q <= hrdata_d;
			end
		end
	end

	// Control registers
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			for (k = 0; k < NCNT; k = k + 1) begin
				ctl_q[k] <= `LRX_CTL_RST;
			end
		end else if (ce_i && wr_ctl) begin
			ctl_q[addr_q[3:2]] <= hwdata_i;
		end
	end

	// ****************************************
	// Event select and counters
	// ****************************************
	// A software load beats an increment in the same cycle
	genvar c;
	generate
		for (c = 0; c < NCNT; c = c + 1) begin : g_cnt
			wire [7:0] code = ctl_q[c][`LRX_CTL_CODE_LSB +: 8];
			wire [7:0] umask = ctl_q[c][`LRX_CTL_UMASK_LSB +: 8];
			wire ext_sel = ctl_q[c][`LRX_CTL_EXT_BIT];
			wire edge_sel = ctl_q[c][`LRX_CTL_EDGE_BIT];
			wire cnt_en = ctl_q[c][`LRX_CTL_EN_BIT];
			// Dedicated credits are filtered by the class mask
			wire ded_hit = ev_cred_ded && umask[credit_class_i];
			wire load = wr_cnt && (addr_q[3:2] == c);
			// Edge history lives in the selector, so it tracks while disabled

			lrx_evsel u_evsel (
				.clk_sys_i(clk_sys_i),
				.srst_i(srst_i),
				.ce_i(ce_i),
				.code_i(code),
				.umask_i(umask),
				.ext_i(ext_sel),
				.edge_i(edge_sel),
				.ev_full_i(ev_full),
				.ev_half_i(ev_half),
				.ev_bypass_i(bypass_i),
				.ev_rxq_ne_i(rxq_nonempty_i),
				.ev_cred_ded_i(ded_hit),
				.ev_cred_shr_i(ev_cred_shr),
				.flit_idle_i(flit_idle),
				.flit_data_i(flit_data),
				.flit_nondata_i(flit_nondata),
				.inc_o(inc[c])
			);

			lrx_count #(
				.W(CNT_W)
			) u_count (
				.clk_sys_i(clk_sys_i),
				.srst_i(srst_i),
				.ce_i(ce_i),
				.en_i(cnt_en),
				.load_i(load),
				.load_val_i(hwdata_i[CNT_W-1:0]),
				.inc_i(inc[c]),
				.cnt_o(cnt[c])
			);
		end
	endgenerate

	// ****************************************
	// Outputs
	// ****************************************
	// Every output comes straight from a flip-flop
	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hready_q;
	assign hresp_o = hresp_q;
	assign rx_lane_en_o = lane_en_q;
	assign rx_unit_width_o = unit_w_q;
	assign rx_units_per_flit_o = units_q;
	assign rx_pwr_state_o = pwr_q;
endmodule // lrx_event_top

// >>> tb/lrx_link_peer.sv
/*
 * Model of the far link layer that sends flits toward the receiver.
 * Assumes the bench picks power mode and flit kinds right after a clock edge.
 */
`timescale 1ns/1ps
`include "lrx_consts.vh"
module lrx_link_peer (
	// Clock
	input wire logic clk_sys_i,
	// Bench commands
	input wire logic [1:0] pwr_i,
	input wire logic [1:0] kind0_i,
	input wire logic [1:0] kind1_i,
	// Toward the receiver
	output logic [1:0] rx_pwr_mode_o,
	output logic [1:0] flit_vld_o,
	output logic [1:0] flit0_kind_o,
	output logic [1:0] flit1_kind_o
);
// ****************************************
// Flit slots
// ****************************************
logic [1:0] k0_q = 2'h0;
logic [1:0] k1_q = 2'h0;
assign rx_pwr_mode_o = pwr_i;
// Both slots filled at full power, half rate at half width, none otherwise
assign flit_vld_o = (pwr_i == `LRX_PWR_FULL) ? 2'h3 :
	(pwr_i == `LRX_PWR_HALF) ? 2'h1 : 2'h0;
// Empty slots carry churn, not a held value
assign flit0_kind_o = flit_vld_o[0] ? kind0_i : ~k0_q;
assign flit1_kind_o = flit_vld_o[1] ? kind1_i : ~k1_q;
always @(posedge clk_sys_i) begin
	k0_q <= flit0_kind_o;
	k1_q <= flit1_kind_o;
end
endmodule // lrx_link_peer

// >>> tb/lrx_event_top_properties.sv
/*
 * Port checker for the receive event block: lane control and bus timing.
 * Assumes it is bound onto lrx_event_top and sees only its ports.
 */
`timescale 1ns/1ps
`include "lrx_consts.vh"
module lrx_event_props #(
	parameter LANES = 20
) (
	// Clock, reset, enable
	input wire clk_sys_i,
	input wire srst_i,
	input wire ce_i,
	// Bus
	input wire hsel_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire hready_i,
	input wire hreadyout_o,
	input wire hresp_o,
	// Lane control
	input wire [1:0] rx_pwr_mode_i,
	input wire [LANES-1:0] rx_lane_en_o,
	input wire [4:0] rx_unit_width_o,
	input wire [3:0] rx_units_per_flit_o,
	input wire [1:0] rx_pwr_state_o
);
// ****************************************
// Assertions
// ****************************************
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (srst_i);
wire bus_go = hsel_i && hready_i && htrans_i[1] && ce_i;
a_state_lag: assert property (ce_i |=> rx_pwr_state_o == $past(rx_pwr_mode_i))
	else $error("power state does not follow mode");
a_half_lanes: assert property (rx_pwr_state_o == `LRX_PWR_HALF
	|-> rx_lane_en_o == ({LANES{1'b1}} >> (LANES / 2)))
	else $error("half-lane mode lane enables wrong");
a_half_width: assert property (rx_pwr_state_o == `LRX_PWR_HALF
	|-> rx_unit_width_o == `LRX_UNIT_HALF && rx_units_per_flit_o == `LRX_UNITS_HALF)
	else $error("half-width unit framing wrong");
a_full_width: assert property ((rx_pwr_state_o == `LRX_PWR_FULL)
	|-> rx_unit_width_o == `LRX_UNIT_FULL && rx_lane_en_o == {LANES{1'b1}})
	else $error("full-width framing wrong");
a_flit_bits: assert property (rx_pwr_state_o != `LRX_PWR_SHUT
	|-> rx_unit_width_o * rx_units_per_flit_o == `LRX_FLIT_BITS)
	else $error("flit size not kept");
a_read_wait: assert property (bus_go && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
	else $error("read wait state wrong");
a_write_fast: assert property (bus_go && hwrite_i |=> hreadyout_o)
	else $error("write stalled");
a_resp_okay: assert property (!hresp_o)
	else $error("error response seen");
endmodule // lrx_event_props

bind lrx_event_top lrx_event_props #(.LANES(LANES)) u_lrx_event_props (.clk_sys_i, .srst_i,
	.ce_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .rx_pwr_mode_i,
	.rx_lane_en_o, .rx_unit_width_o, .rx_units_per_flit_o, .rx_pwr_state_o);

// >>> tb/tb_lrx_event_top.sv
/*
 * Bench for the receive event block: counters set up and read over AHB-Lite.
 * Assumes the link peer model drives the link side; one clock domain.
 */
`timescale 1ns/1ps
`include "lrx_consts.vh"
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD %s exp %h got %h", nm, e, a); end end
module tb_lrx_event_top;
logic clk_sys_i;
logic srst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, byp = 1'b0, cv = 1'b0, cvn = 1'b0;
logic receive_queue = 1'b0, ce = 1'b1, hready, hresp;
logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
logic [1:0] htrans = 2'h0, pwr = `LRX_PWR_SHUT, k0 = 2'h0, k1 = 2'h0, mode, vld, fk0, fk1;
logic [2:0] ccls = 3'h0;
int fail_count = 0, check_count = 0;
// ****************************************
// Design and peer
// ****************************************
lrx_event_top u_lrx_event_top (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce),
	.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
	.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
	.hresp_o(hresp), .rx_pwr_mode_i(mode), .flit_vld_i(vld), .flit0_kind_i(fk0),
	.flit1_kind_i(fk1), .bypass_i(byp), .credit_vld_i(cv), .credit_vnet_i(cvn),
	.credit_class_i(ccls), .rxq_nonempty_i(receive_queue), .rx_lane_en_o(), .rx_unit_width_o(),
	.rx_units_per_flit_o(), .rx_pwr_state_o());
lrx_link_peer u_lrx_link_peer (.clk_sys_i(clk_sys_i), .pwr_i(pwr), .kind0_i(k0),
	.kind1_i(k1), .rx_pwr_mode_o(mode), .flit_vld_o(vld), .flit0_kind_o(fk0),
	.flit1_kind_o(fk1));
initial begin
	clk_sys_i = 1'b0;
	forever #2.5 clk_sys_i = ~clk_sys_i;
end
// ****************************************
// Tasks
// ****************************************
function automatic logic [31:0] ctl(input logic [7:0] c, input logic [7:0] m, input logic e,
	input logic x);
	ctl = {24'h0, c};
	ctl[15:8] = m;
	ctl[`LRX_CTL_EDGE_BIT] = e;
	ctl[`LRX_CTL_EXT_BIT] = x;
	ctl[`LRX_CTL_EN_BIT] = 1'b1;
endfunction
// Entered right after a rising edge
task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
	hsel <= 1'b1;
	htrans <= 2'h2;
	hwrite <= w;
	haddr <= {24'h0, a};
	do @(posedge clk_sys_i); while (hready !== 1'b1);
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= d;
	do @(posedge clk_sys_i); while (hready !== 1'b1);
	rd = hrdata;
endtask
task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
	ahb(1'b0, a, 32'h0);
	`CHK(nm, e, rd)
endtask
task cfg(input logic [31:0] c [4]);
	for (int i = 0; i < 4; i++) begin
		ahb(1'b1, `LRX_OFF_CTL0 + 8'(i) * `LRX_OFF_STEP, c[i]);
		ahb(1'b1, `LRX_OFF_CNT0 + 8'(i) * `LRX_OFF_STEP, 32'h0);
	end
endtask
task cnts(input logic [31:0] e [4], input string nm);
	repeat (3) @(posedge clk_sys_i);
	for (int i = 0; i < 4; i++)
		rchk(`LRX_OFF_CNT0 + 8'(i) * `LRX_OFF_STEP, e[i], nm);
	$display("test %s done", nm);
endtask
task drv(input logic [1:0] m, input logic [1:0] a, input logic [1:0] b, input int n);
	pwr <= m;
	k0 <= a;
	k1 <= b;
	repeat (n) @(posedge clk_sys_i);
endtask
task summarize;
	$display("checks %0d mismatches %0d", check_count, fail_count);
	if (fail_count == 0 && check_count > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
// ****************************************
// Tests
// ****************************************
initial begin
	repeat (16) @(posedge clk_sys_i);
	srst_i <= 1'b0;
	@(posedge clk_sys_i);
	for (int i = 0; i < 4; i++) begin
		rchk(`LRX_OFF_CTL0 + 8'(i) * `LRX_OFF_STEP, `LRX_CTL_RST, "ctl reset");
		rchk(`LRX_OFF_CNT0 + 8'(i) * `LRX_OFF_STEP, 32'h0, "cnt reset");
	end
	rchk(`LRX_OFF_STAT, {30'h0, `LRX_PWR_SHUT}, "stat");
	rchk(8'h40, 32'h0, "unmapped");
	$display("test reset done");
	// Training between half and full must not count as full power
	cfg('{ctl(`LRX_EV_FULL_PWR, 8'h0, 0, 0), ctl(`LRX_EV_HALF_PWR, 8'h0, 0, 0),
		ctl(`LRX_EV_HALF_PWR, 8'h0, 1, 0), ctl(`LRX_EV_FULL_PWR, 8'h0, 1, 0)});
	drv(`LRX_PWR_HALF, 2'h0, 2'h0, 5);
	drv(`LRX_PWR_TRAIN, 2'h0, 2'h0, 3);
	drv(`LRX_PWR_FULL, 2'h0, 2'h0, 4);
	drv(`LRX_PWR_HALF, 2'h0, 2'h0, 2);
	drv(`LRX_PWR_SHUT, 2'h0, 2'h0, 1);
	cnts('{32'h4, 32'h7, 32'h2, 32'h1}, "residency");
	ahb(1'b1, `LRX_OFF_CTL0, {24'h0, `LRX_EV_FULL_PWR});
	drv(`LRX_PWR_FULL, 2'h0, 2'h0, 4);
	drv(`LRX_PWR_SHUT, 2'h0, 2'h0, 3);
	rchk(`LRX_OFF_CNT0, 32'h4, "disabled");
	$display("test disabled done");
	// Flit categories, two slots a cycle
	cfg('{ctl(`LRX_EV_FLIT_G0, 8'h01, 0, 0), ctl(`LRX_EV_FLIT_G0, 8'h02, 0, 0),
		ctl(`LRX_EV_FLIT_G0, 8'h04, 0, 0), ctl(`LRX_EV_FLIT_G0, 8'h07, 0, 0)});
	drv(`LRX_PWR_FULL, `LRX_FLIT_DATA, `LRX_FLIT_NONDATA, 3);
	drv(`LRX_PWR_FULL, `LRX_FLIT_IDLE, `LRX_FLIT_DATA, 2);
	drv(`LRX_PWR_FULL, `LRX_FLIT_NONDATA, `LRX_FLIT_NONDATA, 1);
	drv(`LRX_PWR_SHUT, 2'h0, 2'h0, 1);
	cnts('{32'h2, 32'h5, 32'h5, 32'hC}, "flits");
	// Every class on both networks; only data rsp and non-data rsp selected
	cfg('{ctl(`LRX_EV_BYPASS, 8'h0, 0, 0), ctl(`LRX_EV_RXQ_NE, 8'h0, 0, 0),
		ctl(`LRX_EV_CRED_DED, 8'h21, 0, 1), ctl(`LRX_EV_CRED_SHR, 8'h0, 0, 1)});
	for (int i = 0; i < 12; i++) begin
		cv <= 1'b1;
		cvn <= i[0];
		ccls <= 3'(i / 2);
		byp <= (i < 3);
		receive_queue <= (i < 4);
		@(posedge clk_sys_i);
	end
	cv <= 1'b0;
	byp <= 1'b0;
	receive_queue <= 1'b0;
	@(posedge clk_sys_i);
	cnts('{32'h3, 32'h4, 32'h2, 32'h6}, "credits");
	// Clock enable low freezes counting; counter 0 holds 3 bypasses here
	ahb(1'b1, `LRX_OFF_CTL0, ctl(`LRX_EV_RXQ_NE, 8'h0, 0, 0));
	receive_queue <= 1'b1;
	ce <= 1'b0;
	repeat (5) @(posedge clk_sys_i);
	ce <= 1'b1;
	repeat (2) @(posedge clk_sys_i);
	receive_queue <= 1'b0;
	@(posedge clk_sys_i);
	rchk(`LRX_OFF_CNT0, 32'h5, "clock enable");
	$display("test clock enable done");
	summarize();
end
initial begin
	repeat (5000) @(posedge clk_sys_i);
	fail_count++;
	$display("BAD watchdog exp done got hang");
	summarize();
end
endmodule // tb_lrx_event_top
